// ==== src/pll_ctl_pkg.sv ====
/*
  Shared constants, field layouts and types of the reference-select,
  divider and lock-monitor block.
  Assumes a single 125 MHz system clock and an AXI4-Lite register bus.
*/
`default_nettype none
package pll_ctl_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOL_SET_NS    = 4;
  localparam int LOL_CLR_NS    = 2;
  localparam logic [7:0] LD_TIMEOUT = 8'hFF;

  // register map
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_DIVIDERS = 8'h10;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // control field positions and reset value
  localparam int CTRL_DIV_LSB    = 0;
  localparam int CTRL_POST_LSB   = 4;
  localparam int CTRL_REFSEL_BIT = 6;
  localparam int CTRL_AUTO_BIT   = 7;
  localparam logic [7:0] CTRL_RESET = 8'h18;

  // interrupt status and mask bits
  localparam int IRQ_W      = 3;
  localparam int IRQ_LOST   = 0;
  localparam int IRQ_REGAIN = 1;
  localparam int IRQ_SWITCH = 2;

  // encodings
  localparam logic [3:0] DIV_TEST_CODE = 4'hC;
  localparam logic [1:0] POST_DIV1     = 2'h1;
  localparam logic [1:0] POST_TRI      = 2'h3;

  typedef struct packed {
    logic       auto_en;
    logic       ref_sel;
    logic [1:0] post_sel;
    logic [3:0] div_sel;
  } ctrl_s;

  typedef struct packed {
    logic [8:0] m;
    logic [8:0] r;
    logic       test;
  } mr_s;

  typedef enum logic [1:0] {
    SW_MANUAL   = 2'b00,
    SW_ARMED    = 2'b01,
    SW_SWITCHED = 2'b10
  } sw_state_e;

  typedef enum logic [1:0] {
    LD_IDLE     = 2'b00,
    LD_WAIT_FB  = 2'b01,
    LD_WAIT_REF = 2'b10
  } ld_state_e;

  // feedback/reference pair: r = 4^k, m = r*4, r*2, r or r/4
  function automatic mr_s mr_lookup(input logic [3:0] code);
    mr_s res;
    res.r = 9'h001 << {code[1:0], 1'b0};
    case (code[3:2])
      2'h0:    res.m = res.r << 2;
      2'h1:    res.m = res.r << 1;
      2'h2:    res.m = res.r;
      default: res.m = res.r >> 2;
    endcase
    res.test = (code == DIV_TEST_CODE);
    return res;
  endfunction
endpackage
`default_nettype wire

// ==== src/edge_divider.sv ====
/*
  Rising-edge counting divider: one-cycle pulse on every ratio-th rising
  edge of a sampled input level.
  Assumes the input is synchronous to clk and slower than clk/2.
*/
`default_nettype none
module edge_divider (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // control
  input  wire logic       en,
  input  wire logic [8:0] ratio,
  // signal
  input  wire logic       in_level,
  output logic            edge_pulse
);
  logic       prev;
  logic [8:0] cnt;
  logic       next_prev;
  logic [8:0] next_cnt;
  logic       next_pulse;

  always_comb begin
    next_prev  = in_level;
    next_cnt   = cnt;
    next_pulse = 1'b0;
    if (!en) begin
      next_cnt = 9'h000;
    end else if (in_level && !prev) begin
      if (cnt >= ratio - 9'h001) begin
        next_cnt   = 9'h000;
        next_pulse = 1'b1;
      end else begin
        next_cnt = cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev       <= 1'b0;
      cnt        <= 9'h000;
      edge_pulse <= 1'b0;
    end else begin
      prev       <= next_prev;
      cnt        <= next_cnt;
      edge_pulse <= next_pulse;
    end
  end
endmodule // edge_divider
`default_nettype wire

// ==== src/ref_select_divider_lock_monitor.sv ====
/*
  Digital part of a jitter-attenuating clock PLL: reference mux, feedback
  and reference dividers, phase detector, post divider with tristate,
  lock-loss monitor with hysteresis, automatic reselection, AXI4-Lite regs.
  Assumes all pin inputs are synchronous to clk; oscillator and loop
  filter are outside.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module ref_select_divider_lock_monitor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // reference and oscillator inputs
  input  wire logic        ref_in0_pos,
  input  wire logic        ref_in0_neg,
  input  wire logic        ref_in1_pos,
  input  wire logic        ref_in1_neg,
  input  wire logic        saw_osc_in,
  // phase detector to loop filter
  output logic             pd_up,
  output logic             pd_down,
  // clock output
  output logic             clk_out_pos,
  output logic             clk_out_neg,
  output logic             clk_out_oe,
  // status
  output logic             lock_loss_flag,
  output logic             ref_ack,
  output logic             irq
);
  logic [1:0] rst_sync;
  logic       rstn;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rstn = rst_sync[1];

  // ---------------- AXI4-Lite slave ----------------
  logic        aw_held, w_held;
  logic [7:0]  wr_addr, next_wr_addr;
  logic [31:0] wr_data, next_wr_data;
  logic [3:0]  wr_strb, next_wr_strb;
  logic        next_aw_held, next_w_held, next_awready, next_wready;
  logic        next_bvalid, next_arready, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, rd_word;
  logic        do_write, rd_hit;

  pll_ctl_pkg::ctrl_s  ctrl, next_ctrl;
  pll_ctl_pkg::mr_s    mr;
  logic [pll_ctl_pkg::IRQ_W-1:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask;
  logic [pll_ctl_pkg::IRQ_W-1:0] irq_set, irq_clr;
  pll_ctl_pkg::sw_state_e sw_state, next_sw_state;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      pll_ctl_pkg::ADDR_CTRL:     rd_word = {24'h00_0000, ctrl};
      pll_ctl_pkg::ADDR_STATUS:   rd_word = {26'h000_0000, sw_state, mr.test,
                                             clk_out_oe, ref_ack, lock_loss_flag};
      pll_ctl_pkg::ADDR_IRQ_STAT: rd_word = {29'h0000_0000, irq_stat};
      pll_ctl_pkg::ADDR_IRQ_MASK: rd_word = {29'h0000_0000, irq_mask};
      pll_ctl_pkg::ADDR_DIVIDERS: rd_word = {7'h00, mr.r, 7'h00, mr.m};
      default:                    rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    do_write     = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      do_write     = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_addr == pll_ctl_pkg::ADDR_CTRL ||
                      wr_addr == pll_ctl_pkg::ADDR_STATUS ||
                      wr_addr == pll_ctl_pkg::ADDR_IRQ_STAT ||
                      wr_addr == pll_ctl_pkg::ADDR_IRQ_MASK ||
                      wr_addr == pll_ctl_pkg::ADDR_DIVIDERS) ?
                     pll_ctl_pkg::RESP_OKAY : pll_ctl_pkg::RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? pll_ctl_pkg::RESP_OKAY : pll_ctl_pkg::RESP_SLVERR;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      wr_addr       <= next_wr_addr;
      wr_data       <= next_wr_data;
      wr_strb       <= next_wr_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ---------------- control and interrupt registers ----------------
  logic wr_lane0;
  assign wr_lane0 = do_write && wr_strb[0];

  always_comb begin
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    irq_clr       = '0;
    if (wr_lane0 && wr_addr == pll_ctl_pkg::ADDR_CTRL) begin
      next_ctrl = pll_ctl_pkg::ctrl_s'(wr_data[7:0]);
    end
    if (wr_lane0 && wr_addr == pll_ctl_pkg::ADDR_IRQ_MASK) begin
      next_irq_mask = wr_data[pll_ctl_pkg::IRQ_W-1:0];
    end
    if (wr_lane0 && wr_addr == pll_ctl_pkg::ADDR_IRQ_STAT) begin
      irq_clr = wr_data[pll_ctl_pkg::IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl     <= pll_ctl_pkg::ctrl_s'(pll_ctl_pkg::CTRL_RESET);
      irq_mask <= '0;
      irq_stat <= '0;
      irq      <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & next_irq_mask);
    end
  end

  // ---------------- reference mux and dividers ----------------
  logic       ref_level, div_en;
  logic [1:0] div_in, div_pulse;
  logic [8:0] div_ratio [2];

  assign mr        = pll_ctl_pkg::mr_lookup(ctrl.div_sel);
  assign div_en    = !mr.test;
  assign ref_level = ref_ack ? (ref_in1_pos && !ref_in1_neg)
                             : (ref_in0_pos && !ref_in0_neg);
  assign div_in    = {ref_level, saw_osc_in};
  assign div_ratio[0] = mr.m;
  assign div_ratio[1] = mr.r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_div
      edge_divider u_div (
        .clk        (clk),
        .rstn       (rstn),
        .en         (div_en),
        .ratio      (div_ratio[gi]),
        .in_level   (div_in[gi]),
        .edge_pulse (div_pulse[gi])
      );
    end
  endgenerate

  // ---------------- phase detector ----------------
  logic fb_edge, ref_edge, next_pd_up, next_pd_down;
  assign fb_edge  = div_pulse[0];
  assign ref_edge = div_pulse[1];

  always_comb begin
    next_pd_up   = pd_up || ref_edge;
    next_pd_down = pd_down || fb_edge;
    if (next_pd_up && next_pd_down) begin
      next_pd_up   = 1'b0;
      next_pd_down = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pd_up   <= 1'b0;
      pd_down <= 1'b0;
    end else begin
      pd_up   <= next_pd_up;
      pd_down <= next_pd_down;
    end
  end

  // ---------------- lock-loss monitor ----------------
  pll_ctl_pkg::ld_state_e ld_state, next_ld_state;
  logic [7:0] ld_cnt, next_ld_cnt;
  logic       next_lol, eval;
  logic [7:0] eval_cnt;
  int         err_ns;

  always_comb begin
    next_ld_state = ld_state;
    next_ld_cnt   = ld_cnt;
    next_lol      = lock_loss_flag;
    eval          = 1'b0;
    eval_cnt      = ld_cnt;
    err_ns        = 0;
    case (ld_state)
      pll_ctl_pkg::LD_IDLE: begin
        if (fb_edge && ref_edge) begin
          eval     = 1'b1;
          eval_cnt = 8'h00;
        end else if (fb_edge) begin
          next_ld_state = pll_ctl_pkg::LD_WAIT_REF;
          next_ld_cnt   = 8'h01;
        end else if (ref_edge) begin
          next_ld_state = pll_ctl_pkg::LD_WAIT_FB;
          next_ld_cnt   = 8'h01;
        end
      end
      pll_ctl_pkg::LD_WAIT_FB, pll_ctl_pkg::LD_WAIT_REF: begin
        if ((ld_state == pll_ctl_pkg::LD_WAIT_FB) ? fb_edge : ref_edge) begin
          eval          = 1'b1;
          next_ld_state = pll_ctl_pkg::LD_IDLE;
        end else if (ld_cnt == pll_ctl_pkg::LD_TIMEOUT) begin
          eval          = 1'b1;
          next_ld_state = pll_ctl_pkg::LD_IDLE;
        end else begin
          next_ld_cnt = ld_cnt + 8'h01;
        end
      end
      default: next_ld_state = pll_ctl_pkg::LD_IDLE;
    endcase
    if (eval) begin
      err_ns = int'(eval_cnt) * pll_ctl_pkg::CLK_PERIOD_NS;
      if (err_ns > pll_ctl_pkg::LOL_SET_NS) begin
        next_lol = 1'b1;
      end else if (err_ns < pll_ctl_pkg::LOL_CLR_NS) begin
        next_lol = 1'b0;
      end
    end
    if (!div_en) begin
      next_ld_state = pll_ctl_pkg::LD_IDLE;
      next_ld_cnt   = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ld_state       <= pll_ctl_pkg::LD_IDLE;
      ld_cnt         <= 8'h00;
      lock_loss_flag <= 1'b1;
    end else begin
      ld_state       <= next_ld_state;
      ld_cnt         <= next_ld_cnt;
      lock_loss_flag <= next_lol;
    end
  end

  // ---------------- automatic reselection ----------------
  logic next_ref_ack, switch_evt;

  always_comb begin
    next_sw_state = sw_state;
    next_ref_ack  = ref_ack;
    switch_evt    = 1'b0;
    case (sw_state)
      pll_ctl_pkg::SW_MANUAL: begin
        next_ref_ack = ctrl.ref_sel;
        if (ctrl.auto_en && !lock_loss_flag) begin
          next_sw_state = pll_ctl_pkg::SW_ARMED;
        end
      end
      pll_ctl_pkg::SW_ARMED: begin
        if (!ctrl.auto_en) begin
          next_sw_state = pll_ctl_pkg::SW_MANUAL;
        end else if (lock_loss_flag) begin
          next_ref_ack  = !ref_ack;
          switch_evt    = 1'b1;
          next_sw_state = pll_ctl_pkg::SW_SWITCHED;
        end
      end
      pll_ctl_pkg::SW_SWITCHED: begin
        if (!ctrl.auto_en) begin
          next_sw_state = pll_ctl_pkg::SW_MANUAL;
        end
      end
      default: next_sw_state = pll_ctl_pkg::SW_MANUAL;
    endcase
    irq_set = '0;
    irq_set[pll_ctl_pkg::IRQ_LOST]   = next_lol && !lock_loss_flag;
    irq_set[pll_ctl_pkg::IRQ_REGAIN] = !next_lol && lock_loss_flag;
    irq_set[pll_ctl_pkg::IRQ_SWITCH] = switch_evt;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sw_state <= pll_ctl_pkg::SW_MANUAL;
      ref_ack  <= 1'b0;
    end else begin
      sw_state <= next_sw_state;
      ref_ack  <= next_ref_ack;
    end
  end

  // ---------------- post divider and output driver ----------------
  logic osc_prev, tri_sel, div1_sel, next_pos;

  assign tri_sel  = (ctrl.post_sel == pll_ctl_pkg::POST_TRI);
  assign div1_sel = (ctrl.post_sel == pll_ctl_pkg::POST_DIV1);

  always_comb begin
    if (tri_sel) begin
      next_pos = 1'b0;
    end else if (div1_sel) begin
      next_pos = saw_osc_in;
    end else begin
      next_pos = (saw_osc_in && !osc_prev) ? !clk_out_pos : clk_out_pos;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_prev    <= 1'b0;
      clk_out_pos <= 1'b0;
      clk_out_neg <= 1'b0;
      clk_out_oe  <= 1'b0;
    end else begin
      osc_prev    <= saw_osc_in;
      clk_out_pos <= next_pos;
      clk_out_neg <= !tri_sel && !next_pos;
      clk_out_oe  <= !tri_sel;
    end
  end
endmodule // ref_select_divider_lock_monitor
`default_nettype wire

// ==== bench/pll_ctl_assertions.sv ====
/*
  Port checker for the reference-select, divider and lock-monitor block.
  Assumes one clock, active-low resetn, and is bound to the top module.
*/
`default_nettype none
module pll_ctl_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // clock output
  input wire logic        clk_out_pos,
  input wire logic        clk_out_neg,
  input wire logic        clk_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_tri_pins;
    !clk_out_oe |-> !clk_out_pos && !clk_out_neg;
  endproperty
  property p_out_compl;
    clk_out_oe && $past(clk_out_oe) |-> clk_out_neg != clk_out_pos;
  endproperty
  property p_wr_lat;
    s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_rd_lat;
    s_rd_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == pll_ctl_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty

  a_tri_pins: assert property (p_tri_pins) else $error("driven pin in tristate");
  a_out_compl: assert property (p_out_compl) else $error("outputs not complementary");
  a_wr_lat: assert property (p_wr_lat) else $error("write response timing");
  a_rd_lat: assert property (p_rd_lat) else $error("read response timing");
  a_b_stand: assert property (p_b_stand) else $error("write response dropped");
  a_r_stand: assert property (p_r_stand) else $error("read data dropped");
  a_aw_block: assert property (p_aw_block) else $error("ready while response pending");
  a_b_done: assert property (p_b_done) else $error("write channel not reopened");
  a_r_done: assert property (p_r_done) else $error("read channel not reopened");
  a_err_zero: assert property (p_err_zero) else $error("error read with data");
endmodule // pll_ctl_checker

bind ref_select_divider_lock_monitor pll_ctl_checker pll_ctl_checker_i (
  .clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .clk_out_pos, .clk_out_neg, .clk_out_oe
);
`default_nettype wire

// ==== bench/ref_clock_sources.sv ====
/*
  Two single-ended reference sources and an oscillator locked to them.
  Assumes clk is the system clock; lines change just after its rise.
*/
`default_nettype none
module ref_clock_sources #(
  parameter int HALF = 4
) (
  // control
  input  wire logic clk,
  input  wire logic fail0,
  input  wire logic fail1,
  // pins
  output logic      ref_in0_pos,
  output logic      ref_in0_neg,
  output logic      ref_in1_pos,
  output logic      ref_in1_neg,
  output logic      saw_osc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt = 0;
  logic wave = 1'b0;

  // 8-cycle period, no jitter; detector rate well above 10 MHz at R=1
  always @(posedge clk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      wave <= !wave;
    end
  end
  // failed source stuck low; unused inverting inputs held low
  assign ref_in0_pos = wave & !fail0;
  assign ref_in1_pos = wave & !fail1;
  assign ref_in0_neg = 1'b0;
  assign ref_in1_neg = 1'b0;
  // oscillator at input times M/R for ratio one
  assign saw_osc_in = wave;
endmodule // ref_clock_sources
`default_nettype wire

// ==== bench/ref_select_divider_lock_monitor_tb.sv ====
/*
  Self-checking bench: register bus, dividers, post divider, lock monitor
  and reselection. Assumes ref_clock_sources as the far side.
*/
`default_nettype none
module ref_select_divider_lock_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, resetn = 1'b0, fail0 = 1'b0, fail1 = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        ref_in0_pos, ref_in0_neg, ref_in1_pos, ref_in1_neg, saw_osc_in;
  logic        pd_up, pd_down, clk_out_pos, clk_out_neg, clk_out_oe;
  logic        lock_loss_flag, ref_ack, irq;
  logic [8:0]  mv, rv;
  logic [3:0]  c;
  logic        prev_neg;
  int          n_fail = 0, comparisons = 0, n;

  always #4 clk = ~clk;

  ref_clock_sources ref_clock_sources_i (
    .clk, .fail0, .fail1, .ref_in0_pos, .ref_in0_neg, .ref_in1_pos, .ref_in1_neg, .saw_osc_in
  );
  ref_select_divider_lock_monitor ref_select_divider_lock_monitor_i (
    .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ref_in0_pos, .ref_in0_neg,
    .ref_in1_pos, .ref_in1_neg, .saw_osc_in, .pd_up, .pd_down, .clk_out_pos,
    .clk_out_neg, .clk_out_oe, .lock_loss_flag, .ref_ack, .irq
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin do @(posedge clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata & m, e);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic wait_flag(input logic v);
    int i;
    i = 0;
    while (lock_loss_flag !== v && i < 2000) begin
      @(posedge clk);
      i++;
    end
    check({31'h0, lock_loss_flag}, {31'h0, v});
  endtask

  task automatic test_done();
    $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(pll_ctl_pkg::ADDR_CTRL, 32'hFF, 32'h18, pll_ctl_pkg::RESP_OKAY);
    rd(pll_ctl_pkg::ADDR_IRQ_MASK, 32'h7, 32'h0, pll_ctl_pkg::RESP_OKAY);
    rd(8'h14, 32'hFFFFFFFF, 32'h0, pll_ctl_pkg::RESP_SLVERR);
    wr(8'h14, 32'h1, pll_ctl_pkg::RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      rv = 9'h001 << (2 * c[1:0]);
      mv = (c[3:2] == 2'h0) ? rv << 2 : (c[3:2] == 2'h1) ? rv << 1 : (c[3:2] == 2'h2) ? rv : rv >> 2;
      wr(pll_ctl_pkg::ADDR_CTRL, {28'h1, c}, pll_ctl_pkg::RESP_OKAY);
      if (c == 4'hC)
        rd(pll_ctl_pkg::ADDR_STATUS, 32'h8, 32'h8, pll_ctl_pkg::RESP_OKAY);
      else
        rd(pll_ctl_pkg::ADDR_DIVIDERS, 32'h01FF01FF, {7'h0, rv, 7'h0, mv}, 2'h0);
    end
    $display("test dividers done");
    for (int p = 0; p < 4; p++) begin
      wr(pll_ctl_pkg::ADDR_CTRL, 32'h8 | (p << 4), pll_ctl_pkg::RESP_OKAY);
      repeat (4) @(posedge clk);
      n = 0;
      prev_neg = clk_out_neg;
      repeat (64) begin
        @(posedge clk);
        n += (clk_out_pos && !clk_out_neg && prev_neg) ? 1 : 0;
        prev_neg = clk_out_neg;
      end
      check(n, (p == 1) ? 8 : (p == 3) ? 0 : 4);
      check({31'h0, clk_out_oe}, {31'h0, p != 3});
    end
    $display("test post divider done");
    wr(pll_ctl_pkg::ADDR_CTRL, 32'h18, pll_ctl_pkg::RESP_OKAY);
    wait_flag(1'b0);
    check({30'h0, pd_up, pd_down}, 32'h0);
    wr(pll_ctl_pkg::ADDR_IRQ_MASK, 32'h0, pll_ctl_pkg::RESP_OKAY);
    wr(pll_ctl_pkg::ADDR_IRQ_STAT, 32'h7, pll_ctl_pkg::RESP_OKAY);
    fail0 <= 1'b1;
    wait_flag(1'b1);
    check({31'h0, pd_down}, 32'h1);
    check({31'h0, pd_up}, 32'h0);
    rd(pll_ctl_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1, pll_ctl_pkg::RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    wr(pll_ctl_pkg::ADDR_IRQ_MASK, 32'h7, pll_ctl_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    fail0 <= 1'b0;
    wait_flag(1'b0);
    wr(pll_ctl_pkg::ADDR_IRQ_STAT, 32'h7, pll_ctl_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    $display("test lock monitor done");
    wr(pll_ctl_pkg::ADDR_CTRL, 32'h58, pll_ctl_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    check({31'h0, ref_ack}, 32'h1);
    wr(pll_ctl_pkg::ADDR_CTRL, 32'h18, pll_ctl_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
    check({31'h0, ref_ack}, 32'h0);
    wait_flag(1'b0);
    wr(pll_ctl_pkg::ADDR_CTRL, 32'h98, pll_ctl_pkg::RESP_OKAY);
    rd(pll_ctl_pkg::ADDR_STATUS, 32'h30, 32'h10, pll_ctl_pkg::RESP_OKAY);
    fail0 <= 1'b1;
    wait_flag(1'b1);
    repeat (3) @(posedge clk);
    check({31'h0, ref_ack}, 32'h1);
    rd(pll_ctl_pkg::ADDR_IRQ_STAT, 32'h4, 32'h4, pll_ctl_pkg::RESP_OKAY);
    wait_flag(1'b0);
    fail1 <= 1'b1;
    wait_flag(1'b1);
    repeat (20) @(posedge clk);
    check({31'h0, ref_ack}, 32'h1);
    rd(pll_ctl_pkg::ADDR_STATUS, 32'h30, 32'h20, pll_ctl_pkg::RESP_OKAY);
    $display("test reselection done");
    test_done();
  end
endmodule // ref_select_divider_lock_monitor_tb
`default_nettype wire
